/* rtl/rip_pkg.sv */
// Constants for the indirect port into the real-time clock register file.
// Assumes one system clock and a synchronous active-low reset for transfer state, timer and short strobe only.
package rip_pkg;

    // Data path and internal address widths
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 4;

    // Field positions within the indirect address register
    localparam int BUSY_BIT  = 7;
    localparam int SHORT_BIT = 4;
    localparam int ADDR_MSB  = 3;
    localparam int ADDR_LSB  = 0;

    // Reset value of the short strobe control (enabled)
    localparam logic SHORT_RESET = 1'b1;

    // Internal address of the clock control register
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h5;

    // Transfer lengths in system clock cycles
    localparam int  LEN_W     = 3;
    localparam logic [LEN_W-1:0] LEN_LONG  = 3'h7;
    localparam logic [LEN_W-1:0] LEN_SHORT = 3'h6;

    // Kind of transfer in flight
    typedef enum {
        RIP_IDLE,
        RIP_READ,
        RIP_WRITE
    } rip_state_type;

endpackage : rip_pkg

/* rtl/rip_reg_file.sv */
// Internal register file of the real-time clock, reached only through the port.
// Assumes one write, one addressed read and one tap read per cycle; read data come out of registers.
`timescale 1ns/1ns
module rip_reg_file
    import rip_pkg::*;
#(
    parameter int                ADDR_WIDTH = ADDR_W,
    parameter int                DATA_WIDTH = DATA_W,
    parameter logic [ADDR_W-1:0] TAP_ADDR   = CTRL_ADDR
) (
    input  wire logic                  clock,
    input  wire logic                  wrEn,
    input  wire logic [ADDR_WIDTH-1:0] wrAddr,
    input  wire logic [DATA_WIDTH-1:0] wrData,
    input  wire logic [ADDR_WIDTH-1:0] rdAddr,
    output      logic [DATA_WIDTH-1:0] rdData,
    output      logic [DATA_WIDTH-1:0] tapData
);

    logic [DATA_WIDTH-1:0] mem [2**ADDR_WIDTH];

    // Storage has no reset: clock registers keep their state like real RAM
    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData  <= mem[rdAddr];
        tapData <= mem[TAP_ADDR[ADDR_WIDTH-1:0]];
    end

endmodule : rip_reg_file

/* rtl/rip_strobe_timer.sv */
// Down counter that times one indirect transfer.
// Assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ns
module rip_strobe_timer
    import rip_pkg::*;
#(
    parameter int WIDTH = LEN_W
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] length,
    output      logic             active,
    output      logic             done
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // Load on start, otherwise run down to zero
    always_comb begin
        next_count = count;
        if (start) begin
            next_count = length;
        end else if (count != '0) begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign active = (count != '0);
    assign done   = (count == WIDTH'(1)); // Last cycle of the transfer

endmodule : rip_strobe_timer

/* rtl/rip_indirect_port.sv */
// Indirect access port: an address/select register and a data register through
// which software reads and writes the real-time clock's internal registers.
// Assumes software write strobes are one-cycle pulses on the system clock.
// Overview of operation
// RULE1: The address field chosen in the address register selects the internal register of each transfer.
// RULE2: Bit 7 of the address register reads 1 while a transfer runs and 0 once it ends.
// RULE3: Software polls busy until 0 before each access unless it keeps the recommended spacing.
// RULE4: Any write to the data register starts a write of that byte to the selected register.
// RULE5: Writing 1 to the busy bit starts a read that copies the selected register into the data register.
// RULE6: To read, software selects, sets busy, waits, then reads the data register.
// RULE7: After a read the data register holds its value until the next transfer begins.
// RULE8: Reset leaves the address field and the data register untouched.
// RULE9: With short strobe off a transfer takes 7 system clocks.
// RULE10: With short strobe on a transfer takes 6 system clocks.
// RULE11: Short strobe is on after reset and bit 4 of the address register turns it on or off.
// RULE12: The clock control register sits at internal address 0x05.
// RULE13: Recommended read spacing writes 0x95 then waits two idle slots before reading data.
// RULE14: Recommended write spacing writes the data byte right after the address, then one idle slot.
// RULE15: The internal address lies in the bits below bit 4 so one byte sets busy, short and address.
`timescale 1ns/1ns
module rip_indirect_port
    import rip_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              addrWrite,
    input  wire logic              dataWrite,
    input  wire logic [DATA_W-1:0] writeByte,
    output      logic [DATA_W-1:0] addrRegValue,
    output      logic [DATA_W-1:0] dataRegValue,
    output      logic              busy,
    output      logic [DATA_W-1:0] ctrlRegValue
);

    rip_state_type     state;
    rip_state_type     next_state;
    logic              shortOn;
    logic              next_shortOn;
    logic [ADDR_W-1:0] addrField;
    logic [ADDR_W-1:0] next_addrField;
    logic [DATA_W-1:0] dataReg;
    logic [DATA_W-1:0] next_dataReg;
    logic [ADDR_W-1:0] xferAddr;
    logic [ADDR_W-1:0] next_xferAddr;
    logic              startRead;
    logic              start;
    logic              done;
    logic              memWrEn;
    logic              readLoad;
    logic [DATA_W-1:0] memRdData;
    logic [LEN_W-1:0]  xferLen;

    // A data write always wins over a read request in the same cycle
    assign startRead = addrWrite && writeByte[BUSY_BIT]; // RULE5
    assign start     = dataWrite || startRead;           // RULE4

    // Completion acts only if no new transfer overrides it in that cycle;
    // a reset aborts it, so reset itself never alters the data register
    assign memWrEn  = done && (state == RIP_WRITE) && !start && rst_b; // RULE4 RULE8
    assign readLoad = done && (state == RIP_READ) && !start && rst_b;  // RULE5 RULE8

    // Length is taken from the short strobe value that the same write sets
    assign xferLen = next_shortOn ? LEN_SHORT : LEN_LONG; // RULE9 RULE10

    // Transfer kind tracking
    always_comb begin
        next_state = state;
        case (state)
            RIP_IDLE, RIP_READ, RIP_WRITE: begin
                if (dataWrite) begin
                    next_state = RIP_WRITE;
                end else if (startRead) begin
                    next_state = RIP_READ;
                end else if (done) begin
                    next_state = RIP_IDLE;
                end
            end
            default: begin
                next_state = RIP_IDLE;
            end
        endcase
    end

    // Short strobe control, reset to enabled
    always_comb begin
        next_shortOn = shortOn;
        if (addrWrite) begin
            next_shortOn = writeByte[SHORT_BIT]; // RULE11
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state   <= RIP_IDLE;
            shortOn <= SHORT_RESET; // RULE11
        end else begin
            state   <= next_state;
            shortOn <= next_shortOn;
        end
    end

    // Address field, data byte and latched target: none of these see reset
    always_comb begin
        next_addrField = addrField;
        next_dataReg   = dataReg;
        next_xferAddr  = xferAddr;
        if (addrWrite) begin
            next_addrField = writeByte[ADDR_MSB:ADDR_LSB]; // RULE15
        end
        if (dataWrite) begin
            next_dataReg = writeByte; // RULE4
        end else if (readLoad) begin
            next_dataReg = memRdData; // RULE5 RULE7
        end
        if (start) begin
            next_xferAddr = next_addrField; // RULE1
        end
    end

    // Kept through device reset so software sees its last selection and data
    always_ff @(posedge clock) begin
        addrField <= next_addrField; // RULE8
        dataReg   <= next_dataReg;   // RULE8
        xferAddr  <= next_xferAddr;
    end

    // Times each transfer; a new start restarts it
    rip_strobe_timer #(
        .WIDTH (LEN_W)
    ) u_timer (
        .clock  (clock),
        .rst_b  (rst_b),
        .start  (start),
        .length (xferLen),
        .active (busy), // RULE2
        .done   (done)
    );

    // Internal registers; control register tapped at its fixed address
    rip_reg_file #(
        .ADDR_WIDTH (ADDR_W),
        .DATA_WIDTH (DATA_W),
        .TAP_ADDR   (CTRL_ADDR)
    ) u_regs (
        .clock   (clock),
        .wrEn    (memWrEn),
        .wrAddr  (xferAddr),
        .wrData  (dataReg),
        .rdAddr  (xferAddr),
        .rdData  (memRdData),
        .tapData (ctrlRegValue) // RULE12
    );

    // Register views for software; bits 6 and 5 read as zero
    assign addrRegValue = {busy, 2'b00, shortOn, addrField}; // RULE2 RULE15
    assign dataRegValue = dataReg;

    // Checks

    sequence s_longQuiet6;
        start ##1 (!shortOn && !start)[*6];
    endsequence

    sequence s_shortQuiet5;
        start ##1 (shortOn && !start)[*5];
    endsequence

    property p_longBusy;
        @(posedge clock) disable iff (!rst_b)
        s_longQuiet6 |-> busy;
    endproperty
    a_longBusy: assert property (p_longBusy) else $error("busy dropped before 7 cycles"); // RULE9

    property p_longEnd;
        @(posedge clock) disable iff (!rst_b)
        s_longQuiet6 ##1 (!start) |-> busy ##1 !busy;
    endproperty
    a_longEnd: assert property (p_longEnd) else $error("long transfer not 7 cycles"); // RULE9

    property p_shortBusy;
        @(posedge clock) disable iff (!rst_b)
        s_shortQuiet5 |-> busy;
    endproperty
    a_shortBusy: assert property (p_shortBusy) else $error("busy dropped before 6 cycles"); // RULE10

    property p_shortEnd;
        @(posedge clock) disable iff (!rst_b)
        s_shortQuiet5 ##1 (!start) |-> busy ##1 !busy;
    endproperty
    a_shortEnd: assert property (p_shortEnd) else $error("short transfer not 6 cycles"); // RULE10

    property p_busyRise;
        @(posedge clock) disable iff (!rst_b)
        start |=> busy && addrRegValue[BUSY_BIT];
    endproperty
    a_busyRise: assert property (p_busyRise) else $error("busy not set after start"); // RULE2

    property p_select;
        @(posedge clock) disable iff (!rst_b)
        start |=> xferAddr == addrField;
    endproperty
    a_select: assert property (p_select) else $error("transfer target not selected"); // RULE1

    property p_readLoad;
        @(posedge clock) disable iff (!rst_b)
        (done && state == RIP_READ && !start) |=> dataReg == $past(memRdData);
    endproperty
    a_readLoad: assert property (p_readLoad) else $error("read result not copied"); // RULE5

    property p_dataHold;
        @(posedge clock) disable iff (!rst_b)
        (!dataWrite && !(done && state == RIP_READ)) |=> $stable(dataReg);
    endproperty
    a_dataHold: assert property (p_dataHold) else $error("data register changed"); // RULE7

    property p_ctrlWrite;
        @(posedge clock) disable iff (!rst_b)
        (memWrEn && xferAddr == CTRL_ADDR) |=> ##1 ctrlRegValue == $past(dataReg, 2);
    endproperty
    a_ctrlWrite: assert property (p_ctrlWrite) else $error("control register not written"); // RULE4 RULE12

    property p_shortSet;
        @(posedge clock) disable iff (!rst_b)
        addrWrite |=> shortOn == $past(writeByte[SHORT_BIT]);
    endproperty
    a_shortSet: assert property (p_shortSet) else $error("short strobe bit not taken"); // RULE11

    // Reset state: idle, not busy, short strobe back on
    property p_resetQuiet;
        @(posedge clock)
        !rst_b |=> !busy && shortOn && state == RIP_IDLE;
    endproperty
    a_resetQuiet: assert property (p_resetQuiet) else $error("reset state wrong"); // RULE11

    // Software registers survive reset; checked with reset active on purpose
    property p_addrKeep;
        @(posedge clock)
        !addrWrite |=> $stable(addrField);
    endproperty
    a_addrKeep: assert property (p_addrKeep) else $error("address field changed"); // RULE8

    property p_dataKeep;
        @(posedge clock)
        (!rst_b && !dataWrite) |=> $stable(dataReg);
    endproperty
    a_dataKeep: assert property (p_dataKeep) else $error("data changed in reset"); // RULE8

    // Software writes land in the visible registers
    property p_addrTake;
        @(posedge clock)
        addrWrite |=> {4'h0, addrField} == ($past(writeByte) & 8'h0f);
    endproperty
    a_addrTake: assert property (p_addrTake) else $error("address field not taken"); // RULE15

    property p_dataTake;
        @(posedge clock)
        dataWrite |=> dataRegValue == $past(writeByte);
    endproperty
    a_dataTake: assert property (p_dataTake) else $error("data byte not taken"); // RULE4

    // Busy follows the transfer and nothing else
    property p_idleState;
        @(posedge clock) disable iff (!rst_b)
        !busy |-> state == RIP_IDLE;
    endproperty
    a_idleState: assert property (p_idleState) else $error("idle while state busy"); // RULE2

    property p_busyKeep;
        @(posedge clock) disable iff (!rst_b)
        (busy && !done) |=> busy;
    endproperty
    a_busyKeep: assert property (p_busyKeep) else $error("busy dropped early"); // RULE2

    property p_noSpurious;
        @(posedge clock) disable iff (!rst_b)
        (!busy && !start) |=> !busy;
    endproperty
    a_noSpurious: assert property (p_noSpurious) else $error("busy without start"); // RULE2

    // Kind of transfer chosen by the strobe that started it
    property p_writeStart;
        @(posedge clock) disable iff (!rst_b)
        dataWrite |=> state == RIP_WRITE && busy;
    endproperty
    a_writeStart: assert property (p_writeStart) else $error("write not started"); // RULE4

    property p_readStart;
        @(posedge clock) disable iff (!rst_b)
        (startRead && !dataWrite) |=> state == RIP_READ && busy;
    endproperty
    a_readStart: assert property (p_readStart) else $error("read not started"); // RULE5

    // Last cycle of a transfer that nothing overrides
    sequence s_readEnd;
        state == RIP_READ && done && !start;
    endsequence

    sequence s_writeEnd;
        state == RIP_WRITE && done && !start;
    endsequence

    property p_readEnd;
        @(posedge clock) disable iff (!rst_b)
        s_readEnd |=> !busy && state == RIP_IDLE;
    endproperty
    a_readEnd: assert property (p_readEnd) else $error("read did not finish"); // RULE2 RULE5

    property p_writeEnd;
        @(posedge clock) disable iff (!rst_b)
        s_writeEnd |=> !busy && state == RIP_IDLE;
    endproperty
    a_writeEnd: assert property (p_writeEnd) else $error("write did not finish"); // RULE2 RULE4

endmodule : rip_indirect_port

/* testbench/rip_indirect_port_tb.sv */
// Self-checking bench for the indirect port into the clock register file.
// Assumes single-cycle software strobes and a level busy flag on one clock.
`timescale 1ns/1ns
module rip_indirect_port_tb
    import rip_pkg::*;
;
    logic              clock;
    logic              rst_b;
    logic              addrWrite;
    logic              dataWrite;
    logic [DATA_W-1:0] writeByte;
    logic [DATA_W-1:0] addrRegValue;
    logic [DATA_W-1:0] dataRegValue;
    logic              busy;
    logic [DATA_W-1:0] ctrlRegValue;
    int                nFail;
    int                comparisons;
    int                cycles;
    int                len;

    rip_indirect_port dut_u (
        .clock        (clock),
        .rst_b        (rst_b),
        .addrWrite    (addrWrite),
        .dataWrite    (dataWrite),
        .writeByte    (writeByte),
        .addrRegValue (addrRegValue),
        .dataRegValue (dataRegValue),
        .busy         (busy),
        .ctrlRegValue (ctrlRegValue)
    );

    // System clock, 40 ns period
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Verdict and end of run, reached from the main sequence or the timeout
    task automatic endSim();
        if (nFail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : endSim

    // Byte comparison
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            nFail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp8

    // Cycle count comparison
    task automatic cmpInt(input int got, input int exp, input string what);
        comparisons++;
        if (got != exp) begin
            nFail++;
            $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : cmpInt

    // One software write: sel 0 is the address register, 1 the data register.
    // Strobes stay up after the edge; the next task reuses or lowers them, so
    // no strobe is driven twice in one time step.
    task automatic put(input logic sel, input logic [7:0] b);
        addrWrite = ~sel;
        dataWrite = sel;
        writeByte = b;
        @(posedge clock);
        #1;
    endtask : put

    // Poll busy and count its cycles; bounded so a stuck flag cannot hang
    task automatic waitIdle(output int n);
        addrWrite = 1'b0;
        dataWrite = 1'b0;
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask : waitIdle

    // One more edge so the register file tap has caught up
    task automatic step();
        addrWrite = 1'b0;
        dataWrite = 1'b0;
        @(posedge clock);
        #1;
    endtask : step

    // Hang guard: the whole sequence needs well under a hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            nFail++;
            endSim();
        end
    end

    // Main sequence
    initial begin
        nFail = 0;
        comparisons = 0;
        cycles = 0;
        addrWrite = 1'b0;
        dataWrite = 1'b0;
        writeByte = 8'h00;
        rst_b = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        rst_b = 1'b1;
        cmp8(addrRegValue & 8'h90, 8'h10, "reset view");
        // Short write to the control register, data byte right after address
        put(1'b0, 8'h15);
        cmp8({7'h00, busy}, 8'h00, "no start");
        put(1'b1, 8'ha3);
        cmp8(dataRegValue, 8'ha3, "write data view");
        waitIdle(len);
        cmpInt(len, 6, "short write length");
        step();
        cmp8(ctrlRegValue, 8'ha3, "control written");
        // Long strobe write to another address must not touch the control reg
        put(1'b0, 8'h03);
        cmp8(addrRegValue, 8'h03, "short off");
        put(1'b1, 8'h5c);
        waitIdle(len);
        cmpInt(len, 7, "long write length");
        step();
        cmp8(ctrlRegValue, 8'ha3, "other address");
        // Short read; the data register holds the other byte until the copy
        put(1'b0, 8'h95);
        cmp8(addrRegValue, 8'h95, "busy view");
        waitIdle(len);
        cmpInt(len, 6, "short read length");
        cmp8(addrRegValue, 8'h15, "idle view");
        cmp8(dataRegValue, 8'ha3, "read data");
        put(1'b0, 8'h05);
        put(1'b1, 8'h6e);
        waitIdle(len);
        step();
        cmp8(ctrlRegValue, 8'h6e, "control rewritten");
        // Long read of address 3 over a different byte, then the copy stays put
        put(1'b0, 8'h83);
        waitIdle(len);
        cmpInt(len, 7, "long read length");
        cmp8(dataRegValue, 8'h5c, "read address 3");
        repeat (5) step();
        cmp8(dataRegValue, 8'h5c, "data held");
        // Mid-run reset keeps both registers, short strobe comes back on
        rst_b = 1'b0;
        step();
        rst_b = 1'b1;
        cmp8(addrRegValue, 8'h13, "address kept");
        cmp8(dataRegValue, 8'h5c, "data kept");
        endSim();
    end

endmodule : rip_indirect_port_tb
